/* File: prog_table_defs.svh */
// Purpose: Offsets, field positions, reset values and widths for the
//          program memory table access block.
// Assumes: 16-bit data words and a 24-bit program word.
// Notes:   Definitions only.
`ifndef PROG_TABLE_DEFS_SVH
`define PROG_TABLE_DEFS_SVH

// ==========================================================
// Widths
`define PMT_DATA_W 16
`define PMT_PROG_W 24
`define PMT_PAGE_W 8
`define PMT_EA_W 16
`define PMT_WORD_ADDR_W 23
`define PMT_LANES 3
`define PMT_REG_ADDR_W 4

// ==========================================================
// Register offsets
`define PMT_OFF_TABLE_PAGE 4'h0
`define PMT_OFF_STATUS 4'h2

// ==========================================================
// Field positions
`define PMT_PAGE_CONFIG_BIT 7
`define PMT_STATUS_BUSY_BIT 0
`define PMT_STATUS_CONFIG_BIT 1
`define PMT_STATUS_WRITE_BIT 2

// ==========================================================
// Reset values
`define PMT_TABLE_PAGE_RST 8'h00
`define PMT_REG_RDATA_RST 16'h0000

// ==========================================================
// Byte lane enables of a flash write
`define PMT_BE_NONE 3'h0
`define PMT_BE_LOW_BYTE 3'h1
`define PMT_BE_MID_BYTE 3'h2
`define PMT_BE_LOW_WORD 3'h3
`define PMT_BE_HIGH_BYTE 3'h4

`endif

/* File: prog_table_pkg.sv */
// Purpose: Types shared by the program memory table access block.
// Assumes: Constants come from prog_table_defs.svh.
// Notes:   Types only.
`include "prog_table_defs.svh"

package prog_table_pkg;

  // ==========================================================
  // Table operations and access sequencer states
  typedef enum logic [1:0] {
    OP_READ_LOW,
    OP_READ_HIGH,
    OP_WRITE_LOW,
    OP_WRITE_HIGH
  } table_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WAIT
  } access_state_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    table_op_e op;
    logic byteMode;
    logic [`PMT_EA_W-1:0] effAddr;
    logic [`PMT_DATA_W-1:0] wrData;
  } table_req_s;

  typedef struct packed {
    logic strobe;
    logic configSpace;
    logic [`PMT_WORD_ADDR_W-1:0] wordAddr;
    logic [`PMT_LANES-1:0] byteEn;
    logic [`PMT_PROG_W-1:0] data;
  } flash_wr_s;

endpackage

/* File: reset_release.sv */
// Purpose: Two-stage release of the asynchronous active-low reset.
// Assumes: nrst may rise at any time relative to clock.
// Notes:   Assertion is immediate, release takes two edges.
`timescale 1ns/1ps

module reset_release (
  // Clock and raw reset
  input wire logic clock,
  input wire logic nrst,
  // Released reset
  output logic rstN
);

  logic stage1;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rstN <= stage1;
    end
  end

endmodule

/* File: table_read_lane.sv */
// Purpose: Steers a 24-bit program word onto the 16-bit data bus.
// Assumes: Program word already fetched from the flash array.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "prog_table_defs.svh"

module table_read_lane (
  // Fetched word and selection
  input wire logic [`PMT_PROG_W-1:0] progWord,
  input wire logic highSpace,
  input wire logic byteMode,
  input wire logic byteSel,
  // Data to the CPU
  output logic [`PMT_DATA_W-1:0] data
);

  // ==========================================================
  // Lane steering
  always_comb begin
    data = 16'h0000;
    if (!highSpace) begin
      if (!byteMode) begin
        data = progWord[15:0]; // see R5
      end else if (byteSel) begin
        data = {8'h00, progWord[15:8]}; // see R6
      end else begin
        data = {8'h00, progWord[7:0]}; // see R6
      end
    end else begin
      // Upper space is only 8 bits wide, high data byte is phantom
      if (!byteMode) begin
        data = {8'h00, progWord[23:16]}; // see R7
      end else if (!byteSel) begin
        data = {8'h00, progWord[23:16]}; // see R8
      end else begin
        data = 16'h0000; // see R8
      end
    end
  end

endmodule

/* File: program_memory_table_access.sv */
// Purpose: Table read and write path from the CPU to program flash.
// Assumes: Flash returns read data in the cycle after flashRdEn.
// Notes:   One access at a time; busy refuses new requests.
//
// Notes on behaviour
// R1: Low-word operations reach the low 16 program bits directly.
// R2: High-word operations alone reach the upper 8 program bits.
// R3: Program words step by two, so bit 0 is never a word address bit.
// R4: Two parallel 16-bit spaces; low and high operations pick one.
// R5: Word-mode low read returns program bits 15..0.
// R6: Byte-mode low read returns upper byte when select is one, else lower.
// R7: Word-mode high read returns bits 23..16, upper data byte zero.
// R8: Byte-mode high read returns zero when the phantom byte is selected.
// R9: Every table read supports both byte and word size.
// R10: The table page register supplies the page for every operation.
// R11: Page bit 7 clear selects user space, set selects configuration.
// R12: Table writes pass bytes or words on to flash programming logic.
// R13: Full address is the page above the 16-bit effective address.
// R14: Byte select is bit 0 of the effective address.
`timescale 1ns/1ps
`include "prog_table_defs.svh"

module program_memory_table_access (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEnable,
  // Register port
  input wire logic [`PMT_REG_ADDR_W-1:0] regAddr,
  input wire logic [`PMT_DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [`PMT_DATA_W-1:0] regRdData,
  // CPU table requests
  input wire logic reqValid,
  input wire prog_table_pkg::table_req_s req,
  output logic busy,
  output logic done,
  output logic [`PMT_DATA_W-1:0] readData,
  // Flash array
  output logic flashRdEn,
  output logic flashConfigSpace,
  output logic [`PMT_WORD_ADDR_W-1:0] flashWordAddr,
  input wire logic [`PMT_PROG_W-1:0] flashRdData,
  output prog_table_pkg::flash_wr_s flashWr
);

  // ==========================================================
  // Declarations
  logic rstN;
  logic [`PMT_PAGE_W-1:0] tablePage;
  logic [`PMT_PAGE_W-1:0] next_tablePage;
  logic [`PMT_DATA_W-1:0] next_regRdData;
  prog_table_pkg::access_state_e state;
  prog_table_pkg::access_state_e next_state;
  prog_table_pkg::table_op_e op;
  prog_table_pkg::table_op_e next_op;
  logic byteMode;
  logic next_byteMode;
  logic byteSel;
  logic next_byteSel;
  logic lastWrite;
  logic next_lastWrite;
  logic next_busy;
  logic next_done;
  logic [`PMT_DATA_W-1:0] next_readData;
  logic next_flashRdEn;
  logic next_flashConfigSpace;
  logic [`PMT_WORD_ADDR_W-1:0] next_flashWordAddr;
  prog_table_pkg::flash_wr_s next_flashWr;
  logic [`PMT_PROG_W-1:0] fullAddr;
  logic [`PMT_DATA_W-1:0] laneData;
  logic isRead;

  // ==========================================================
  // Helpers
  function automatic logic [`PMT_PROG_W-1:0] formAddress(
    input logic [`PMT_PAGE_W-1:0] page,
    input logic [`PMT_EA_W-1:0] ea
  );
    formAddress = {page, ea}; // see R13 see R10
  endfunction

  function automatic prog_table_pkg::flash_wr_s writeBeat(
    input prog_table_pkg::table_req_s r,
    input logic [`PMT_PROG_W-1:0] addr
  );
    prog_table_pkg::flash_wr_s w;
    w.strobe = 1'b1;
    w.configSpace = addr[`PMT_PROG_W-1]; // see R11
    w.wordAddr = addr[`PMT_PROG_W-1:1]; // see R3
    w.byteEn = `PMT_BE_NONE;
    w.data = {`PMT_PROG_W{1'b0}};
    if (r.op == prog_table_pkg::OP_WRITE_LOW) begin
      if (!r.byteMode) begin
        w.byteEn = `PMT_BE_LOW_WORD; // see R12 see R1
        w.data = {8'h00, r.wrData};
      end else if (r.effAddr[0]) begin
        w.byteEn = `PMT_BE_MID_BYTE; // see R14
        w.data = {8'h00, r.wrData[7:0], 8'h00};
      end else begin
        w.byteEn = `PMT_BE_LOW_BYTE; // see R14
        w.data = {16'h0000, r.wrData[7:0]};
      end
    end else begin
      // Phantom byte writes are dropped with no lane enabled
      w.data = {r.wrData[7:0], 16'h0000};
      if (!r.byteMode || !r.effAddr[0]) begin
        w.byteEn = `PMT_BE_HIGH_BYTE; // see R2 see R12
      end
    end
    writeBeat = w;
  endfunction

  // ==========================================================
  // Reset release
  reset_release resetSync (
    .clock(clock),
    .nrst(nrst),
    .rstN(rstN)
  );

  // ==========================================================
  // Read lane steering
  table_read_lane readLane (
    .progWord(flashRdData),
    .highSpace(op == prog_table_pkg::OP_READ_HIGH), // see R4
    .byteMode(byteMode),
    .byteSel(byteSel),
    .data(laneData)
  );

  // ==========================================================
  // Register port
  always_comb begin
    next_tablePage = tablePage;
    next_regRdData = `PMT_REG_RDATA_RST;
    if (regWrStrobe && regAddr == `PMT_OFF_TABLE_PAGE) begin
      next_tablePage = regWrData[`PMT_PAGE_W-1:0];
    end
    if (regRdStrobe) begin
      if (regAddr == `PMT_OFF_TABLE_PAGE) begin
        next_regRdData = {8'h00, tablePage};
      end else if (regAddr == `PMT_OFF_STATUS) begin
        next_regRdData[`PMT_STATUS_BUSY_BIT] = busy;
        next_regRdData[`PMT_STATUS_CONFIG_BIT] = flashConfigSpace;
        next_regRdData[`PMT_STATUS_WRITE_BIT] = lastWrite;
      end else begin
        next_regRdData = `PMT_REG_RDATA_RST;
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tablePage <= `PMT_TABLE_PAGE_RST;
      regRdData <= `PMT_REG_RDATA_RST;
    end else if (clockEnable) begin
      tablePage <= next_tablePage;
      regRdData <= next_regRdData;
    end
  end

  // ==========================================================
  // Access sequencer
  // Page is sampled at acceptance, so later page writes do not
  // disturb an access already in flight.
  always_comb begin
    fullAddr = formAddress(tablePage, req.effAddr);
    isRead = (req.op == prog_table_pkg::OP_READ_LOW) ||
             (req.op == prog_table_pkg::OP_READ_HIGH);
    next_state = state;
    next_op = op;
    next_byteMode = byteMode;
    next_byteSel = byteSel;
    next_lastWrite = lastWrite;
    next_busy = busy;
    next_done = 1'b0;
    next_readData = readData;
    next_flashRdEn = 1'b0;
    next_flashConfigSpace = flashConfigSpace;
    next_flashWordAddr = flashWordAddr;
    next_flashWr = flashWr;
    next_flashWr.strobe = 1'b0;
    case (state)
      prog_table_pkg::ST_IDLE: begin
        if (reqValid) begin
          next_op = req.op;
          next_byteMode = req.byteMode; // see R9
          next_byteSel = req.effAddr[0]; // see R14
          next_flashConfigSpace = fullAddr[`PMT_PROG_W-1]; // see R11
          next_lastWrite = !isRead;
          if (isRead) begin
            next_flashRdEn = 1'b1;
            next_flashWordAddr = fullAddr[`PMT_PROG_W-1:1]; // see R3
            next_busy = 1'b1;
            next_state = prog_table_pkg::ST_READ;
          end else begin
            next_flashWr = writeBeat(req, fullAddr); // see R12
            next_done = 1'b1;
          end
        end
      end
      prog_table_pkg::ST_READ: begin
        next_state = prog_table_pkg::ST_WAIT;
      end
      prog_table_pkg::ST_WAIT: begin
        next_readData = laneData; // see R1 see R2
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = prog_table_pkg::ST_IDLE;
      end
      default: begin
        next_state = prog_table_pkg::ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state <= prog_table_pkg::ST_IDLE;
      op <= prog_table_pkg::OP_READ_LOW;
      byteMode <= 1'b0;
      byteSel <= 1'b0;
      lastWrite <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      readData <= 16'h0000;
      flashRdEn <= 1'b0;
      flashConfigSpace <= 1'b0;
      flashWordAddr <= 23'h000000;
      flashWr <= '0;
    end else if (clockEnable) begin
      state <= next_state;
      op <= next_op;
      byteMode <= next_byteMode;
      byteSel <= next_byteSel;
      lastWrite <= next_lastWrite;
      busy <= next_busy;
      done <= next_done;
      readData <= next_readData;
      flashRdEn <= next_flashRdEn;
      flashConfigSpace <= next_flashConfigSpace;
      flashWordAddr <= next_flashWordAddr;
      flashWr <= next_flashWr;
    end
  end

  // ==========================================================
  // Checks
  readLowWord_a: assert property ( // see R5
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_WAIT &&
    op == prog_table_pkg::OP_READ_LOW && !byteMode
    |=> done && readData == $past(flashRdData[15:0]))
    else $error("low word read mismatch");

  readLowByte_a: assert property ( // see R6
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_WAIT &&
    op == prog_table_pkg::OP_READ_LOW && byteMode
    |=> readData == ($past(byteSel) ?
                     {8'h00, $past(flashRdData[15:8])} :
                     {8'h00, $past(flashRdData[7:0])}))
    else $error("low byte read mismatch");

  readHighWord_a: assert property ( // see R7
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_WAIT &&
    op == prog_table_pkg::OP_READ_HIGH && !byteMode
    |=> readData == {8'h00, $past(flashRdData[23:16])})
    else $error("high word read mismatch");

  phantomByte_a: assert property ( // see R8
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_WAIT &&
    op == prog_table_pkg::OP_READ_HIGH && byteMode && byteSel
    |=> done && readData == 16'h0000)
    else $error("phantom byte not zero");

  fetchAddress_a: assert property ( // see R13
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_IDLE && reqValid &&
    (req.op == prog_table_pkg::OP_READ_LOW ||
     req.op == prog_table_pkg::OP_READ_HIGH)
    |=> flashRdEn && busy &&
        flashWordAddr == {$past(tablePage), $past(req.effAddr[15:1])})
    else $error("fetch address wrong");

  configSpace_a: assert property ( // see R11
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_IDLE && reqValid
    |=> flashConfigSpace == $past(tablePage[`PMT_PAGE_CONFIG_BIT]))
    else $error("space select wrong");

  writeLowWord_a: assert property ( // see R12
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_IDLE && reqValid &&
    req.op == prog_table_pkg::OP_WRITE_LOW && !req.byteMode
    |=> flashWr.strobe && done && flashWr.byteEn == `PMT_BE_LOW_WORD &&
        flashWr.data[15:0] == $past(req.wrData))
    else $error("low word write wrong");

  writeByteSel_a: assert property ( // see R14
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_IDLE && reqValid &&
    req.op == prog_table_pkg::OP_WRITE_LOW && req.byteMode
    |=> flashWr.byteEn == ($past(req.effAddr[0]) ?
                           `PMT_BE_MID_BYTE : `PMT_BE_LOW_BYTE))
    else $error("write byte lane wrong");

  writeHigh_a: assert property ( // see R2
    @(posedge clock) disable iff (!rstN)
    clockEnable && state == prog_table_pkg::ST_IDLE && reqValid &&
    req.op == prog_table_pkg::OP_WRITE_HIGH
    |=> flashWr.strobe && flashWr.data[23:16] == $past(req.wrData[7:0])
        && flashWr.byteEn == (($past(req.byteMode) &&
            $past(req.effAddr[0])) ? `PMT_BE_NONE : `PMT_BE_HIGH_BYTE))
    else $error("high write lane wrong");

endmodule

/* File: flash_array_model.sv */
// Purpose: Behavioural program flash array facing the table access block.
// Assumes: Read data are due in the cycle after a read strobe only.
// Notes:   Unwritten words follow a fixed pattern of their address.
`timescale 1ns/1ps
`include "prog_table_defs.svh"

module flash_array_model (
  // Clock
  input wire logic clock,
  // Read side
  input wire logic rdEn,
  input wire logic configSpace,
  input wire logic [`PMT_WORD_ADDR_W-1:0] wordAddr,
  output logic [`PMT_PROG_W-1:0] rdData,
  // Write side
  input wire prog_table_pkg::flash_wr_s wr
);
  logic [`PMT_PROG_W-1:0] mem [logic [`PMT_WORD_ADDR_W:0]];

  function automatic logic [23:0] fetch(input logic [23:0] key);
    if (mem.exists(key)) begin
      return mem[key];
    end
    return {key[22:15] ^ key[7:0], key[15:0] ^ 16'hc3a5};
  endfunction

  // ==========================================================
  // Read port
  initial rdData = 24'h000000;
  // Stale data inverted so a late sample cannot pass by luck
  always @(posedge clock) begin
    if (rdEn) begin
      rdData <= fetch({configSpace, wordAddr});
    end else begin
      rdData <= ~rdData;
    end
  end

  // ==========================================================
  // Programming port, lane by lane
  always @(posedge clock) begin
    logic [23:0] w;
    w = fetch({wr.configSpace, wr.wordAddr});
    for (int i = 0; i < 3; i++) begin
      if (wr.byteEn[i]) begin
        w[i*8 +: 8] = wr.data[i*8 +: 8];
      end
    end
    if (wr.strobe) begin
      mem[{wr.configSpace, wr.wordAddr}] = w;
    end
  end
endmodule

/* File: program_memory_table_access_test.sv */
// Purpose: Self-checking bench of the program memory table access block.
// Assumes: Flash model answers one cycle after each read strobe.
// Notes:   One scenario freezes a read by lowering clock enable.
`timescale 1ns/1ps
`include "prog_table_defs.svh"

module program_memory_table_access_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clockEnable = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [15:0] regRdData;
  logic reqValid = 1'b0;
  prog_table_pkg::table_req_s req = '0;
  logic busy;
  logic done;
  logic [15:0] readData;
  logic flashRdEn;
  logic flashConfigSpace;
  logic [22:0] flashWordAddr;
  logic [23:0] flashRdData;
  prog_table_pkg::flash_wr_s flashWr;
  int failCount = 0;
  int checks = 0;

  program_memory_table_access program_memory_table_access_inst (
    .clock(clock), .nrst(nrst), .clockEnable(clockEnable),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .reqValid(reqValid), .req(req), .busy(busy), .done(done),
    .readData(readData), .flashRdEn(flashRdEn),
    .flashConfigSpace(flashConfigSpace), .flashWordAddr(flashWordAddr),
    .flashRdData(flashRdData), .flashWr(flashWr));

  flash_array_model flash_array_model_inst (
    .clock(clock), .rdEn(flashRdEn), .configSpace(flashConfigSpace),
    .wordAddr(flashWordAddr), .rdData(flashRdData), .wr(flashWr));

  initial begin
    forever #4 clock = ~clock;
  end

  // ==========================================================
  // Shared helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
  endtask

  task automatic regRead(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask

  // ==========================================================
  // Table read: address, latency and lane steering
  task automatic tableRead(input logic [7:0] pg,
      input prog_table_pkg::table_op_e op, input logic bm,
      input logic [15:0] ea);
    logic [22:0] a;
    logic [23:0] w;
    logic [15:0] exp;
    int n;
    a = {pg, ea[15:1]};
    w = {a[22:15] ^ a[7:0], a[15:0] ^ 16'hc3a5};
    if (op == prog_table_pkg::OP_READ_LOW) begin
      exp = bm ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
    end else begin
      exp = (bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
    end
    regWrite(4'h0, {8'h00, pg});
    @(posedge clock);
    reqValid <= 1'b1;
    req <= '{op, bm, ea, 16'h0000};
    @(posedge clock);
    reqValid <= 1'b0;
    #1;
    check({flashRdEn, busy, flashConfigSpace, flashWordAddr},
          {2'b11, pg[7], a});
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 8) begin
      failCount++;
      give_verdict();
    end
    check(n, 2);
    check(readData, exp);
  endtask

  // ==========================================================
  // Table write: lanes handed to the programming logic
  task automatic tableWrite(input logic [7:0] pg,
      input prog_table_pkg::table_op_e op, input logic bm,
      input logic [15:0] ea, input logic [15:0] wd);
    logic [2:0] be;
    logic [23:0] dat;
    logic [23:0] mask;
    if (op == prog_table_pkg::OP_WRITE_HIGH) begin
      be = (bm && ea[0]) ? 3'h0 : 3'h4;
      // Phantom write enables no lane, so no data bit is due
      dat = (bm && ea[0]) ? 24'h000000 : {wd[7:0], 16'h0000};
    end else if (!bm) begin
      be = 3'h3;
      dat = {8'h00, wd};
    end else begin
      be = ea[0] ? 3'h2 : 3'h1;
      dat = ea[0] ? {8'h00, wd[7:0], 8'h00} : {16'h0000, wd[7:0]};
    end
    mask = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    regWrite(4'h0, {8'h00, pg});
    @(posedge clock);
    reqValid <= 1'b1;
    req <= '{op, bm, ea, wd};
    @(posedge clock);
    reqValid <= 1'b0;
    #1;
    check({flashWr.strobe, done, flashWr.configSpace, flashWr.wordAddr},
          {2'b11, pg[7], pg, ea[15:1]});
    check(flashWr.byteEn, be);
    check(flashWr.data & mask, dat);
    @(posedge clock);
    #1;
    check({flashWr.strobe, done}, 2'b00);
  endtask

  // ==========================================================
  // Requests arriving while a read is in flight
  task automatic busyRefuse();
    regWrite(4'h0, 16'h0002);
    @(posedge clock);
    reqValid <= 1'b1;
    req <= '{prog_table_pkg::OP_READ_LOW, 1'b0, 16'h0010, 16'h0000};
    @(posedge clock);
    req <= '{prog_table_pkg::OP_WRITE_LOW, 1'b0, 16'h0020, 16'hbeef};
    @(posedge clock);
    #1;
    check({flashWr.strobe, busy}, 2'b01);
    @(posedge clock);
    reqValid <= 1'b0;
    #1;
    check({flashWr.strobe, done, busy}, 3'b010);
    @(posedge clock);
    #1;
    check({flashWr.strobe, flashRdEn}, 2'b00);
  endtask

  // ==========================================================
  // Clock enable low freezes a read in flight
  task automatic freezeHold();
    regWrite(4'h0, 16'h0001);
    @(posedge clock);
    reqValid <= 1'b1;
    req <= '{prog_table_pkg::OP_READ_LOW, 1'b0, 16'h0040, 16'h0000};
    @(posedge clock);
    reqValid <= 1'b0;
    clockEnable <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check({flashRdEn, busy, done}, 3'b110);
    @(posedge clock);
    clockEnable <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({busy, done}, 2'b01);
    // Model pattern of page 1, word 16'h0020
    check(readData, 16'h4385);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check({busy, done, flashRdEn, flashWr.strobe, regRdData}, 20'h0);
    regRead(4'h0, 16'h0000);
    regWrite(4'h0, 16'h12a5);
    regRead(4'h0, 16'h00a5);
    regRead(4'hf, 16'h0000);
    regWrite(4'hf, 16'hffff);
    regRead(4'h0, 16'h00a5);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        tableRead(p[0] ? 8'h81 : 8'h01,
                  k[2] ? prog_table_pkg::OP_READ_HIGH
                       : prog_table_pkg::OP_READ_LOW,
                  k[1], k[0] ? 16'hfffb : 16'h1234);
      end
    end
    regRead(4'h2, 16'h0002);
    for (int k = 0; k < 6; k++) begin
      tableWrite(k[0] ? 8'h7f : 8'h80,
                 k[2] ? prog_table_pkg::OP_WRITE_HIGH
                      : prog_table_pkg::OP_WRITE_LOW,
                 k[1] | k[2], {15'h2b3c, k[0]}, 16'h9d6e);
    end
    regRead(4'h2, 16'h0004);
    tableWrite(8'h81, prog_table_pkg::OP_WRITE_HIGH, 1'b1, 16'h4441,
               16'h00c7);
    tableWrite(8'h81, prog_table_pkg::OP_WRITE_HIGH, 1'b0, 16'h4440,
               16'h00c7);
    regRead(4'h2, 16'h0006);
    busyRefuse();
    freezeHold();
    give_verdict();
  end
endmodule
